// file: include/nfc_pkg.sv
// Package for the NOR flash host controller: commands, pin carrier, timing
package nfc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Bus cycle phase times and hardware reset pulse and recovery times
  localparam int T_SETUP_NS    = 100;
  localparam int T_STROBE_NS   = 300;
  localparam int T_HOLD_NS     = 100;
  localparam int T_RP_NS       = 500;
  localparam int T_RH_NS       = 50;
  localparam int T_SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_STROBE_CYC  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HOLD_CYC    = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RP_CYC      = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RH_CYC      = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  localparam logic [11:0] UNLOCK1_WORD = 12'h0555;
  localparam logic [11:0] UNLOCK2_WORD = 12'h02aa;
  localparam logic [11:0] UNLOCK1_BYTE = 12'h0aaa;
  localparam logic [11:0] UNLOCK2_BYTE = 12'h0555;
  localparam logic [7:0]  DAT_UNLOCK1  = 8'haa;
  localparam logic [7:0]  DAT_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_ID       = 8'h90;
  localparam logic [7:0]  CMD_PROG     = 8'ha0;
  localparam logic [7:0]  CMD_ESETUP   = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ER  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ER  = 8'h30;

  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;

  typedef enum logic [2:0] {
    NFC_OP_READ, NFC_OP_RESET, NFC_OP_ID, NFC_OP_PROG,
    NFC_OP_CHIP_ER, NFC_OP_SECT_ER, NFC_OP_HWRESET, NFC_OP_WRITE
  } nfc_op_t;

  typedef struct packed {
    nfc_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } nfc_req_t;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic                hard_reset_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_o;
    logic                dq_oe;
  } nfc_pins_t;
endpackage

// file: verilog/nfc_cycle.sv
// Single flash bus cycle engine: one read or one write strobe
`timescale 1ns/10ps
module nfc_cycle
  import nfc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_sync,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata_ff,
  output logic                   ce_n_ff,
  output logic                   oe_n_ff,
  output logic                   we_n_ff,
  output logic                   dq_oe_ff,
  output logic [ADDR_W-1:0]      addr_ff,
  output logic [DATA_W-1:0]      dq_o_ff
);
  typedef enum logic [1:0] {NFC_C_IDLE, NFC_C_SETUP, NFC_C_STROBE, NFC_C_HOLD} nfc_cst_t;
  nfc_cst_t          st_ff, nxt_st;
  logic [7:0]        cnt_ff, nxt_cnt;
  logic              wr_ff, nxt_wr;
  logic [DATA_W-1:0] nxt_rdata, nxt_dq_o;
  logic [ADDR_W-1:0] nxt_addr;
  logic              nxt_ce_n, nxt_oe_n, nxt_we_n, nxt_dq_oe;

  assign busy = (st_ff != NFC_C_IDLE);
  assign done = (st_ff == NFC_C_HOLD) && (cnt_ff == 8'h01);

  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_wr    = wr_ff;
    nxt_rdata = rdata_ff;
    nxt_addr  = addr_ff;
    nxt_dq_o  = dq_o_ff;
    nxt_ce_n  = ce_n_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_we_n  = we_n_ff;
    nxt_dq_oe = dq_oe_ff;
    case (st_ff)
      NFC_C_IDLE: begin
        if (start) begin
          nxt_st    = NFC_C_SETUP;
          nxt_cnt   = 8'(T_SETUP_CYC);
          nxt_wr    = is_write;
          nxt_addr  = addr;
          nxt_dq_o  = wdata;
          nxt_ce_n  = 1'b0;
          // Output enable stays high on writes so the flash never fights us
          nxt_dq_oe = is_write;
        end
      end
      NFC_C_SETUP: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) begin
          nxt_st   = NFC_C_STROBE;
          nxt_cnt  = 8'(T_STROBE_CYC);
          nxt_we_n = !wr_ff;
          nxt_oe_n = wr_ff;
        end
      end
      NFC_C_STROBE: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) begin
          nxt_st    = NFC_C_HOLD;
          nxt_cnt   = 8'(T_HOLD_CYC);
          // Data latched by the flash on this we_n rise; ce_n rises later
          nxt_we_n  = 1'b1;
          nxt_oe_n  = 1'b1;
          if (!wr_ff) nxt_rdata = dq_sync;
        end
      end
      NFC_C_HOLD: begin
        nxt_cnt = cnt_ff - 8'h01;
        if (cnt_ff == 8'h01) begin
          nxt_st    = NFC_C_IDLE;
          nxt_ce_n  = 1'b1;
          nxt_dq_oe = 1'b0;
        end
      end
      default: nxt_st = NFC_C_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff    <= NFC_C_IDLE;
      cnt_ff   <= 8'h00;
      wr_ff    <= 1'b0;
      rdata_ff <= 16'h0000;
      addr_ff  <= 20'h0_0000;
      dq_o_ff  <= 16'h0000;
      ce_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      dq_oe_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      wr_ff    <= nxt_wr;
      rdata_ff <= nxt_rdata;
      addr_ff  <= nxt_addr;
      dq_o_ff  <= nxt_dq_o;
      ce_n_ff  <= nxt_ce_n;
      oe_n_ff  <= nxt_oe_n;
      we_n_ff  <= nxt_we_n;
      dq_oe_ff <= nxt_dq_oe;
    end
  end
endmodule

// file: verilog/nfc_host.sv
// Host controller driving an asynchronous parallel NOR flash over its pins
// What this block does
// - Reads drive chip select and output enable low, write enable high.
// - Writes drive write enable and chip select low, output enable high.
// - Host waits reset-high-to-read after reset before reading.
// - Erase is six writes: unlock pair, 80H, unlock pair, 10H or 30H.
// - Host writes reset after timeout fail or to leave identification mode.
// - Unlock addresses 555H/2AAH in word mode, AAAH/555H in byte mode.
// - Sector erase sends one sector load per request; no further loads follow the 30H write.
`timescale 1ns/10ps
module nfc_host
  import nfc_pkg::*;
#(
  parameter int POLL_LIMIT = 1000000
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire nfc_req_t          req,
  input  wire logic              req_valid,
  input  wire logic              byte_mode,
  output logic                   req_ready,
  output logic                   resp_valid_ff,
  output logic [DATA_W-1:0]      resp_data_ff,
  output logic                   resp_fail_ff,
  output nfc_pins_t              pins,
  input  wire logic [DATA_W-1:0] dq_i,
  input  wire logic              ready_busy_n
);
  typedef enum logic [2:0] {
    NFC_IDLE, NFC_SEQ, NFC_POLL_A, NFC_POLL_B, NFC_RST_LOW, NFC_RST_REC, NFC_DONE
  } nfc_st_t;

  nfc_st_t           st_ff, nxt_st;
  nfc_req_t          cur_ff, nxt_cur;
  logic [2:0]        idx_ff, nxt_idx;
  logic [31:0]       cnt_ff, nxt_cnt;
  logic [DATA_W-1:0] first_ff, nxt_first;
  logic              rst_n_ff, nxt_rst_n;
  logic              nxt_rv, nxt_fail;
  logic              q5_ff, nxt_q5;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] dq_m_ff, dq_s_ff;
  logic              rb_m_ff, rb_s_ff;

  logic              cyc_start, cyc_wr, cyc_busy, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata, cyc_rdata;
  logic [2:0]        seq_len;
  logic [11:0]       ul1, ul2;

  // Pins are asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_m_ff <= 16'h0000;
      dq_s_ff <= 16'h0000;
      rb_m_ff <= 1'b1;
      rb_s_ff <= 1'b1;
    end else begin
      dq_m_ff <= dq_i;
      dq_s_ff <= dq_m_ff;
      rb_m_ff <= ready_busy_n;
      rb_s_ff <= rb_m_ff;
    end
  end

  assign ul1 = byte_mode ? UNLOCK1_BYTE : UNLOCK1_WORD;
  assign ul2 = byte_mode ? UNLOCK2_BYTE : UNLOCK2_WORD;

  always_comb begin
    case (cur_ff.op)
      NFC_OP_ID, NFC_OP_PROG:       seq_len = 3'd4;
      NFC_OP_CHIP_ER, NFC_OP_SECT_ER: seq_len = 3'd6;
      default:                      seq_len = 3'd1;
    endcase
  end

  // Address and data of write number idx of the current command sequence
  always_comb begin
    cyc_wr    = (cur_ff.op != NFC_OP_READ);
    cyc_addr  = {8'h00, ul1};
    cyc_wdata = {8'h00, DAT_UNLOCK1};
    case (cur_ff.op)
      NFC_OP_READ, NFC_OP_WRITE: begin
        cyc_addr  = cur_ff.addr;
        cyc_wdata = cur_ff.data;
      end
      NFC_OP_RESET: cyc_wdata = {8'h00, CMD_RESET};
      default: begin
        case (idx_ff)
          3'd1, 3'd4: begin
            cyc_addr  = {8'h00, ul2};
            cyc_wdata = {8'h00, DAT_UNLOCK2};
          end
          3'd2: begin
            cyc_wdata = (cur_ff.op == NFC_OP_ID)   ? {8'h00, CMD_ID} :
                        (cur_ff.op == NFC_OP_PROG) ? {8'h00, CMD_PROG} :
                        {8'h00, CMD_ESETUP};
          end
          3'd3: begin
            if (cur_ff.op == NFC_OP_PROG) begin
              cyc_addr  = cur_ff.addr;
              cyc_wdata = cur_ff.data;
            end
          end
          3'd5: begin
            if (cur_ff.op == NFC_OP_SECT_ER) begin
              // One sector per request, so the load window simply closes
              cyc_addr  = cur_ff.addr;
              cyc_wdata = {8'h00, CMD_SECT_ER};
            end else begin
              cyc_wdata = {8'h00, CMD_CHIP_ER};
            end
          end
          default: ;
        endcase
      end
    endcase
  end

  assign req_ready = (st_ff == NFC_IDLE);

  always_comb begin
    nxt_st    = st_ff;
    nxt_cur   = cur_ff;
    nxt_idx   = idx_ff;
    nxt_cnt   = cnt_ff;
    nxt_first = first_ff;
    nxt_rst_n = rst_n_ff;
    nxt_q5    = q5_ff;
    nxt_rv    = 1'b0;
    nxt_fail  = resp_fail_ff;
    nxt_rdata = resp_data_ff;
    cyc_start = 1'b0;
    case (st_ff)
      NFC_IDLE: begin
        if (req_valid) begin
          nxt_cur  = req;
          nxt_idx  = 3'd0;
          nxt_fail = 1'b0;
          nxt_q5   = 1'b0;
          if (req.op == NFC_OP_HWRESET) begin
            nxt_st    = NFC_RST_LOW;
            nxt_cnt   = 32'(T_RP_CYC);
            nxt_rst_n = 1'b0;
          end else begin
            nxt_st = NFC_SEQ;
          end
        end
      end
      NFC_SEQ: begin
        cyc_start = !cyc_busy && !cyc_done;
        if (cyc_done) begin
          nxt_idx = idx_ff + 3'd1;
          if (idx_ff + 3'd1 == seq_len) begin
            nxt_rdata = cyc_rdata;
            // Programs and erases run on their own; poll until they finish
            if (cur_ff.op == NFC_OP_PROG || cur_ff.op == NFC_OP_CHIP_ER ||
                cur_ff.op == NFC_OP_SECT_ER) begin
              nxt_st  = NFC_POLL_A;
              nxt_cnt = 32'(POLL_LIMIT);
            end else begin
              nxt_st = NFC_DONE;
            end
          end
        end
      end
      NFC_POLL_A, NFC_POLL_B: begin
        // Two back-to-back status reads compare the toggle bit
        cyc_start = !cyc_busy && !cyc_done;
        if (cyc_done) begin
          if (st_ff == NFC_POLL_A) begin
            nxt_first = cyc_rdata;
            nxt_st    = NFC_POLL_B;
          end else begin
            // Limit counts pairs; a set timeout bit may be array data read just
            // after completion, so it must show on two pairs in a row
            nxt_cnt = cnt_ff - 32'd1;
            nxt_q5  = cyc_rdata[TIMEOUT_BIT];
            if (cyc_rdata[TOGGLE_BIT] == first_ff[TOGGLE_BIT] && rb_s_ff) begin
              nxt_st = NFC_DONE;
            end else if ((cyc_rdata[TIMEOUT_BIT] && q5_ff) || cnt_ff == 32'd1) begin
              // Failed algorithm: flash needs a reset command to read again
              nxt_fail   = 1'b1;
              nxt_cur.op = NFC_OP_RESET;
              nxt_idx    = 3'd0;
              nxt_st     = NFC_SEQ;
            end else begin
              nxt_st = NFC_POLL_A;
            end
          end
        end
      end
      NFC_RST_LOW: begin
        nxt_cnt = cnt_ff - 32'd1;
        if (cnt_ff == 32'd1) begin
          nxt_rst_n = 1'b1;
          nxt_st    = NFC_RST_REC;
          nxt_cnt   = 32'(T_RH_CYC);
        end
      end
      NFC_RST_REC: begin
        // Wait out reset-to-read and any internal reset shown as busy
        if (cnt_ff != 32'd0) nxt_cnt = cnt_ff - 32'd1;
        if (cnt_ff == 32'd0 && rb_s_ff) nxt_st = NFC_DONE;
      end
      NFC_DONE: begin
        nxt_rv = 1'b1;
        nxt_st = NFC_IDLE;
      end
      default: nxt_st = NFC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff         <= NFC_IDLE;
      cur_ff        <= '0;
      idx_ff        <= 3'd0;
      cnt_ff        <= 32'd0;
      first_ff      <= 16'h0000;
      rst_n_ff      <= 1'b1;
      q5_ff         <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_fail_ff  <= 1'b0;
      resp_data_ff  <= 16'h0000;
    end else begin
      st_ff         <= nxt_st;
      cur_ff        <= nxt_cur;
      idx_ff        <= nxt_idx;
      cnt_ff        <= nxt_cnt;
      first_ff      <= nxt_first;
      rst_n_ff      <= nxt_rst_n;
      q5_ff         <= nxt_q5;
      resp_valid_ff <= nxt_rv;
      resp_fail_ff  <= nxt_fail;
      resp_data_ff  <= nxt_rdata;
    end
  end

  nfc_cycle u_cycle (
    .clk      (clk),
    .rst      (rst),
    .start    (cyc_start),
    .is_write (cyc_wr && st_ff == NFC_SEQ),
    .addr     (cyc_addr),
    .wdata    (cyc_wdata),
    .dq_sync  (dq_s_ff),
    .busy     (cyc_busy),
    .done     (cyc_done),
    .rdata_ff (cyc_rdata),
    .ce_n_ff  (pins.ce_n),
    .oe_n_ff  (pins.oe_n),
    .we_n_ff  (pins.we_n),
    .dq_oe_ff (pins.dq_oe),
    .addr_ff  (pins.addr),
    .dq_o_ff  (pins.dq_o)
  );
  assign pins.hard_reset_n = rst_n_ff;
endmodule

// file: bench/nfc_flash_model.sv
// Behavioural NOR flash device answering the host controller pins
`timescale 1ns/10ps
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter logic [15:0] ARR_XOR = 16'h3c3c,
  parameter logic [7:0]  MAKER   = 8'h11,  // Arbitrary value
  parameter logic [7:0]  DEVCODE = 8'h77,  // Arbitrary value
  parameter int          ERASE_T = 60,
  parameter int          RDY_T   = 8
)
(
  input  wire nfc_pins_t    pins,
  input  wire logic         byte_mode,
  input  wire logic         erase_fail,
  output logic [DATA_W-1:0] dq_i,
  output logic              ready_busy_n
);
  int                step = 0;
  int                bcnt = 0;
  int                rcnt = 0;
  logic              id_ff = 0;
  logic              fail = 0;
  logic              erased = 0;
  logic              tgl = 0;
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] last = '0;
  wire               live = pins.hard_reset_n === 1'b1;
  wire               wr = live && !pins.ce_n && !pins.we_n;
  wire               rd = live && !pins.ce_n && !pins.oe_n;
  wire               algo = bcnt != 0 || fail;
  // Data is taken on the rising strobe, so decode happens there
  always @(negedge wr) begin : decode
    logic [7:0] d;
    logic       ok1;
    logic       ok2;
    d = pins.dq_o[7:0];
    ok1 = pins.addr[11:0] == (byte_mode ? 12'h0aaa : 12'h0555);
    ok2 = pins.addr[11:0] == (byte_mode ? 12'h0555 : 12'h02aa);
    if (bcnt == 0 && d == 8'hf0) begin
      step = 0;
      id_ff = 0;
      fail = 0;
    end else if (bcnt == 0 && !fail) begin
      case (step)
        0, 3: step = ok1 && d == 8'haa ? step + 1 : 0;
        1, 4: step = ok2 && d == 8'h55 ? step + 1 : 0;
        2: begin
          id_ff = id_ff || (ok1 && d == 8'h90);
          step = !ok1 ? 0 : d == 8'h80 ? 3 : d == 8'ha0 ? 6 : 0;
        end
        5: begin
          // Erase starts at once: only one sector load is ever sent
          if ((ok1 && d == 8'h10) || d == 8'h30) begin
            bcnt = ERASE_T;
            fail = erase_fail;
            erased = erased || !erase_fail;
          end
          step = 0;
        end
        default: begin
          bcnt = ERASE_T / 4;
          step = 0;
        end
      endcase
    end
  end
  // Algorithm runs on its own time, whatever the strobes do
  always #100 begin
    if (bcnt > 0) bcnt = bcnt - 1;
    if (rcnt > 0) rcnt = rcnt - 1;
  end
  always @(negedge pins.hard_reset_n) begin
    rcnt = algo ? RDY_T : 0;
    bcnt = 0;
    fail = 0;
    step = 0;
    id_ff = 0;
  end
  always @(posedge rd) begin
    if (algo) tgl = ~tgl;
  end
  always @* begin
    if (algo)
      val = {8'h00, 1'b0, tgl, fail && bcnt == 0, 5'h00};
    else if (id_ff)
      val = {8'h00, pins.addr[0] ? DEVCODE : MAKER};
    else
      val = erased ? 16'hffff : pins.addr[15:0] ^ ARR_XOR;
  end
  always @(val or rd) begin
    if (rd) last = val;
  end
  // No pull-ups on data: released lines show the inverse of the last value
  assign dq_i = rd ? val : ~last;
  assign ready_busy_n = !(algo || rcnt != 0);
endmodule

// file: bench/nfc_host_monitor.sv
// Pin protocol checker for the flash host controller
`timescale 1ns/10ps
module nfc_host_monitor
  import nfc_pkg::*;
#(
  parameter int POLL_LIMIT = 1000000
)
(
  input wire logic      clk,
  input wire logic      rst,
  input wire nfc_req_t  req,
  input wire logic      req_valid,
  input wire logic      req_ready,
  input wire logic      resp_valid_ff,
  input wire nfc_pins_t pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_pulse_s;
    !pins.we_n [*3] ##1 pins.we_n;
  endsequence
  sequence rd_pulse_s;
    !pins.oe_n [*3] ##1 pins.oe_n;
  endsequence
  sequence read_take_s;
    req_valid && req_ready && req.op == NFC_OP_READ;
  endsequence
  strobe_excl_a: assert property (!pins.oe_n |-> pins.we_n)
    else $error("read and write strobes low together");
  drive_quiet_a: assert property (pins.dq_oe |-> pins.oe_n)
    else $error("host drives data while output enable is low");
  ce_gate_a: assert property ((!pins.oe_n || !pins.we_n) |-> !pins.ce_n)
    else $error("strobe low without chip select");
  wr_pulse_a: assert property ($fell(pins.we_n) |-> wr_pulse_s)
    else $error("write strobe width wrong");
  rd_pulse_a: assert property ($fell(pins.oe_n) |-> rd_pulse_s)
    else $error("read strobe width wrong");
  lines_hold_a: assert property (!pins.we_n && !$past(pins.we_n) |->
    $stable(pins.addr) && $stable(pins.dq_o)) else $error("lines moved in write");
  data_latch_a: assert property ($rose(pins.we_n) |-> !pins.ce_n)
    else $error("chip select released before write strobe");
  hwrst_width_a: assert property ($fell(pins.hard_reset_n) |->
    !pins.hard_reset_n [*5]) else $error("hardware reset pulse too short");
  read_gap_a: assert property ($rose(pins.hard_reset_n) |-> pins.oe_n [*2])
    else $error("read too soon after hardware reset");
  read_time_a: assert property (read_take_s |-> ##[7:10] resp_valid_ff)
    else $error("read answer late");
endmodule

bind nfc_host nfc_host_monitor #(.POLL_LIMIT(POLL_LIMIT)) u_mon (
  .clk(clk), .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
  .resp_valid_ff(resp_valid_ff), .pins(pins)
);

// file: bench/tb.sv
// Self-checking testbench for the flash host controller
`timescale 1ns/10ps
module tb
  import nfc_pkg::*;
;
  localparam logic [15:0] ARR_XOR = 16'h3c3c;
  localparam logic [7:0]  MAKER   = 8'h11;  // Arbitrary value
  localparam logic [7:0]  DEVCODE = 8'h77;  // Arbitrary value
  typedef struct {
    nfc_op_t     op;
    logic [19:0] addr;
    logic [15:0] data;
    logic        bm;
    logic [2:0]  kind;
  } nfc_row_t;
  logic              clk = 0;
  logic              rst = 1;
  nfc_req_t          req = '0;
  logic              req_valid = 0;
  logic              byte_mode = 0;
  logic              erase_fail = 0;
  logic              req_ready;
  logic              resp_valid_ff;
  logic [DATA_W-1:0] resp_data_ff;
  logic              resp_fail_ff;
  nfc_pins_t         pins;
  logic [DATA_W-1:0] dq_i;
  logic              ready_busy_n;
  int                n_errors = 0;
  int                cmp_count = 0;
  logic [15:0]       want;
  nfc_row_t rows [24] = '{
    '{NFC_OP_READ,    20'h0_0123, 16'h0000, 1'b0, 3'd1},
    '{NFC_OP_WRITE,   20'h0_0555, 16'h00aa, 1'b0, 3'd0},
    '{NFC_OP_WRITE,   20'h0_0123, 16'h0055, 1'b0, 3'd0},
    '{NFC_OP_WRITE,   20'h0_0555, 16'h0090, 1'b0, 3'd0},
    '{NFC_OP_READ,    20'h0_0000, 16'h0000, 1'b0, 3'd1},
    '{NFC_OP_WRITE,   20'h0_0555, 16'h00aa, 1'b0, 3'd0},
    '{NFC_OP_WRITE,   20'h0_02aa, 16'h0055, 1'b0, 3'd0},
    '{NFC_OP_RESET,   20'h3_1234, 16'h0000, 1'b0, 3'd0},
    '{NFC_OP_WRITE,   20'h0_0555, 16'h0090, 1'b0, 3'd0},
    '{NFC_OP_READ,    20'h0_0001, 16'h0000, 1'b0, 3'd1},
    '{NFC_OP_ID,      20'h0_0000, 16'h0000, 1'b0, 3'd0},
    '{NFC_OP_READ,    20'h0_0000, 16'h0000, 1'b0, 3'd2},
    '{NFC_OP_READ,    20'h7_fff1, 16'h0000, 1'b0, 3'd3},
    '{NFC_OP_RESET,   20'h0_0000, 16'h0000, 1'b0, 3'd0},
    '{NFC_OP_READ,    20'h0_0001, 16'h0000, 1'b0, 3'd1},
    '{NFC_OP_ID,      20'h0_0000, 16'h0000, 1'b1, 3'd0},
    '{NFC_OP_READ,    20'h0_0001, 16'h0000, 1'b1, 3'd3},
    '{NFC_OP_RESET,   20'h0_0000, 16'h0000, 1'b1, 3'd0},
    '{NFC_OP_PROG,    20'h0_0200, 16'h1234, 1'b0, 3'd0},
    '{NFC_OP_READ,    20'h0_0040, 16'h0000, 1'b0, 3'd1},
    '{NFC_OP_SECT_ER, 20'h1_0000, 16'h0000, 1'b1, 3'd0},
    '{NFC_OP_READ,    20'h0_0040, 16'h0000, 1'b0, 3'd4},
    '{NFC_OP_CHIP_ER, 20'h0_0000, 16'h0000, 1'b0, 3'd0},
    '{NFC_OP_READ,    20'h0_0002, 16'h0000, 1'b0, 3'd4}
  };

  nfc_host #(.POLL_LIMIT(20)) u_dut (
    .clk(clk), .rst(rst), .req(req), .req_valid(req_valid), .byte_mode(byte_mode),
    .req_ready(req_ready), .resp_valid_ff(resp_valid_ff), .resp_data_ff(resp_data_ff),
    .resp_fail_ff(resp_fail_ff), .pins(pins), .dq_i(dq_i), .ready_busy_n(ready_busy_n)
  );
  nfc_flash_model #(.ARR_XOR(ARR_XOR), .MAKER(MAKER), .DEVCODE(DEVCODE)) u_flash (
    .pins(pins), .byte_mode(byte_mode), .erase_fail(erase_fail), .dq_i(dq_i),
    .ready_busy_n(ready_busy_n)
  );

  always #50 clk = ~clk;

  task automatic chk(string nm, logic [15:0] exp_v, logic [15:0] got);
    cmp_count++;
    if (got !== exp_v) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp_v, got);
    end
  endtask

  task automatic run(nfc_op_t op, logic [19:0] a, logic [15:0] d, logic bm);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    req = '{op, a, d};
    byte_mode = bm;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    while (resp_valid_ff !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("resp_valid", 16'h0001, 16'(resp_valid_ff));
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Whole run is under a thousand cycles; twenty thousand means a hang
  initial begin
    #2_000_000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    chk("idle_pins", 16'h001e, 16'({pins.ce_n, pins.oe_n, pins.we_n,
      pins.hard_reset_n, pins.dq_oe}));
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].addr, rows[i].data, rows[i].bm);
      case (rows[i].kind)
        3'd1: want = rows[i].addr[15:0] ^ ARR_XOR;
        3'd2: want = {8'h00, MAKER};
        3'd3: want = {8'h00, DEVCODE};
        default: want = 16'hffff;
      endcase
      if (rows[i].kind != 3'd0) chk("resp_data", want, resp_data_ff);
      chk("resp_fail", 16'h0000, 16'(resp_fail_ff));
    end
    erase_fail = 1;
    run(NFC_OP_CHIP_ER, 20'h0_0000, 16'h0000, 1'b0);
    erase_fail = 0;
    chk("resp_fail", 16'h0001, 16'(resp_fail_ff));
    run(NFC_OP_READ, 20'h0_0008, 16'h0000, 1'b0);
    chk("resp_data", 16'hffff, resp_data_ff);
    run(NFC_OP_ID, 20'h0_0000, 16'h0000, 1'b0);
    run(NFC_OP_HWRESET, 20'h0_0000, 16'h0000, 1'b0);
    run(NFC_OP_READ, 20'h0_0000, 16'h0000, 1'b0);
    chk("resp_data", 16'hffff, resp_data_ff);
    // Second reset lands in the middle of a read strobe
    req = '{NFC_OP_READ, 20'h0_0005, 16'h0000};
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    repeat (3) @(negedge clk);
    rst = 1;
    @(negedge clk);
    chk("reset_pins", 16'h001e, 16'({pins.ce_n, pins.oe_n, pins.we_n,
      pins.hard_reset_n, pins.dq_oe}));
    rst = 0;
    run(NFC_OP_READ, 20'h0_0005, 16'h0000, 1'b0);
    chk("resp_data", 16'hffff, resp_data_ff);
    conclude();
  end
endmodule
